// ---- hdl/lsf_supervisor.sv ----
`timescale 1ns/1ps
module lsf_supervisor
  import lsf_pkg::*;
#(
  parameter int unsigned LATCH_CLEAR_CYCLES = LATCH_CLEAR_CYC
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_reset_n,
  input  wire logic                   i_latch_all_mode,
  input  wire logic                   i_enable,
  input  wire logic                   i_dimming,
  input  wire logic                   i_alarm_in,
  input  wire logic [NUM_STRINGS-1:0] i_above_short_threshold,
  input  wire logic [NUM_STRINGS-1:0] i_at_regulation,
  input  wire logic [NUM_STRINGS-1:0] i_string_used,
  output logic                        o_alarm_out,
  output logic                        o_alarm_oe_n,
  output logic                        o_boost_enable,
  output logic                        o_disconnect_on,
  output logic [NUM_STRINGS-1:0]      o_sink_enable,
  output logic                        o_fault_flag
);

  typedef struct packed {
    logic [2:0]             sync_en;
    logic [2:0]             sync_dim;
    logic [2:0]             sync_alm;
    logic [NUM_STRINGS*3-1:0] sync_hi;
    logic [NUM_STRINGS*3-1:0] sync_reg;
    logic                   en_q;
    logic                   dim_q;
    logic                   alm_q;
    logic [NUM_STRINGS-1:0] hi_q;
    logic [NUM_STRINGS-1:0] reg_q;
    logic                   dim_prev;
    logic [NUM_STRINGS*QUAL_W-1:0] qual;
    logic [NUM_STRINGS-1:0] disabled;
    logic [NUM_STRINGS-1:0] faulted;
    logic [NUM_STRINGS*PASS_W-1:0] passes;
    logic                   latched;
    logic [CLR_W-1:0]       clr_cnt;
    logic                   alarm_low;
    logic                   boost;
    logic [NUM_STRINGS-1:0] sink;
    logic                   alarm_oe_n;
    logic                   disc_on;
    logic [2:0]             rel_hold;
  } lsf_state_type;

  // Idle levels after reset: wire seen high, pin released, switch on.
  // Starting the alarm filter high avoids a false external low.
  localparam lsf_state_type RST_ST = '{
    sync_alm:   3'h7,
    alm_q:      1'b1,
    alarm_oe_n: 1'b1,
    disc_on:    1'b1,
    default:    '0
  };

  lsf_state_type st;
  lsf_state_type next_st;

  // Agreement filter for a synchronised input: bits 1 and 2 must match, else hold
  function automatic logic lsf_filt(input logic [2:0] s, input logic q);
    lsf_filt = (s[1] == s[2]) ? s[1] : q;
  endfunction

  logic [QUAL_W-1:0] q_cur;
  logic [PASS_W-1:0] p_cur;
  logic              cond;
  logic              dim_rise;
  logic              ext_low;
  logic              others_reg;
  logic [NUM_STRINGS-1:0] cond_vec;
  logic [NUM_STRINGS-1:0] hit_vec;

  // Next-state logic
  always_comb begin
    next_st = st;
    q_cur = '0;
    p_cur = '0;
    cond = 1'b0;
    others_reg = 1'b0;
    cond_vec = ALL_OFF;
    hit_vec = ALL_OFF;
    // Synchronisers: new sample in bit 0, compare bits 1 and 2
    next_st.sync_en  = {st.sync_en[1:0], i_enable};
    next_st.sync_dim = {st.sync_dim[1:0], i_dimming};
    next_st.sync_alm = {st.sync_alm[1:0], i_alarm_in};
    next_st.en_q  = lsf_filt(st.sync_en, st.en_q);
    next_st.dim_q = lsf_filt(st.sync_dim, st.dim_q);
    next_st.alm_q = lsf_filt(st.sync_alm, st.alm_q);
    for (int i = 0; i < NUM_STRINGS; i++) begin
      next_st.sync_hi[i*3 +: 3]  = {st.sync_hi[i*3 +: 2],
                                    i_above_short_threshold[i]};
      next_st.sync_reg[i*3 +: 3] = {st.sync_reg[i*3 +: 2],
                                    i_at_regulation[i]};
      next_st.hi_q[i]  = lsf_filt(st.sync_hi[i*3 +: 3], st.hi_q[i]);
      next_st.reg_q[i] = lsf_filt(st.sync_reg[i*3 +: 3], st.reg_q[i]);
    end
    next_st.dim_prev = st.dim_q;
    dim_rise = st.dim_q & ~st.dim_prev;
    // External pull-down only seen when we are not driving low, and
    // not while our own release is still crossing the synchroniser.
    // A peer pulling in that window is seen a few cycles late.
    ext_low = ~st.alm_q & ~st.alarm_low & (st.rel_hold == 3'h0);

    // Per-string partial-short qualification and retry
    for (int i = 0; i < NUM_STRINGS; i++) begin
      others_reg = 1'b0;
      for (int j = 0; j < NUM_STRINGS; j++) begin
        if (j != i) begin
          others_reg = others_reg | (st.reg_q[j] & st.sink[j]
                                     & i_string_used[j]);
        end
      end
      // Evaluate only in dimming high with string driven
      cond = st.dim_q & st.sink[i] & i_string_used[i] & st.hi_q[i]
             & others_reg;
      cond_vec[i] = cond;
      // Last counting cycle before qualification
      hit_vec[i]  = cond & (st.qual[i*QUAL_W +: QUAL_W]
                            == QUAL_W'(SHORT_QUAL_CYC - 1));
      q_cur = st.qual[i*QUAL_W +: QUAL_W];
      p_cur = st.passes[i*PASS_W +: PASS_W];
      if (!cond) begin
        q_cur = '0;
      end else if (q_cur < QUAL_W'(SHORT_QUAL_CYC)) begin
        q_cur = q_cur + 1'b1;
      end
      if (cond && q_cur == QUAL_W'(SHORT_QUAL_CYC)) begin
        // Qualified: disable string, mark faulted
        next_st.disabled[i] = 1'b1;
        next_st.faulted[i]  = 1'b1;
        p_cur = '0;
        q_cur = '0;
        if (i_latch_all_mode) begin
          next_st.latched = 1'b1;
        end
      end else if (dim_rise && st.faulted[i]) begin
        // Retry on each new dimming-high phase
        next_st.disabled[i] = 1'b0;
        if (!st.disabled[i] || st.passes[i*PASS_W +: PASS_W] != '0) begin
          // Previous phase was clean: count it
          p_cur = p_cur + 1'b1;
        end else begin
          p_cur = 2'h1; // first retry phase counts as clean start
        end
        if (p_cur >= CLEAN_PASSES_TO_RELEASE) begin
          next_st.faulted[i] = 1'b0;
          p_cur = '0;
        end
      end
      next_st.qual[i*QUAL_W +: QUAL_W]   = q_cur;
      next_st.passes[i*PASS_W +: PASS_W] = p_cur;
    end

    // Latched clear by long low on enable or dimming
    if (!st.en_q || !st.dim_q) begin
      if (st.clr_cnt < CLR_W'(LATCH_CLEAR_CYCLES)) begin
        next_st.clr_cnt = st.clr_cnt + 1'b1;
      end
    end else begin
      next_st.clr_cnt = '0;
    end
    if (st.latched && st.clr_cnt == CLR_W'(LATCH_CLEAR_CYCLES)) begin
      next_st.latched  = 1'b0;
      next_st.faulted  = ALL_OFF;
      next_st.disabled = ALL_OFF;
      next_st.passes   = '0;
    end
    if (next_st.latched) begin
      next_st.faulted = st.faulted | next_st.faulted; // set wins
    end

    // Outputs
    next_st.alarm_low = (|next_st.faulted) | next_st.latched;
    next_st.alarm_oe_n = ~next_st.alarm_low;
    next_st.disc_on    = ~next_st.latched;
    // Mask own release until the wire level has passed the synchroniser
    if (st.alarm_low && !next_st.alarm_low) begin
      next_st.rel_hold = RELEASE_MASK_CYC;
    end else if (st.rel_hold != 3'h0) begin
      next_st.rel_hold = st.rel_hold - 3'h1;
    end
    if (i_latch_all_mode && (ext_low || next_st.latched)) begin
      next_st.boost = 1'b0;
      next_st.sink  = ALL_OFF;
    end else begin
      // Resume when external low gone, nothing pending
      next_st.boost = st.en_q;
      next_st.sink  = st.en_q ? (i_string_used & ~next_st.disabled)
                              : ALL_OFF;
    end
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // Open-drain alarm: drive low, enable active low
  // Open-drain data is always low; only the enable moves
  assign o_alarm_out     = 1'b0;
  assign o_alarm_oe_n    = st.alarm_oe_n;
  assign o_boost_enable  = st.boost;
  assign o_disconnect_on = st.disc_on; // stays on for external low
  assign o_sink_enable   = st.sink;
  assign o_fault_flag    = st.alarm_low;

  // Assertions
  // Qualifying string goes off on the edge after its last count
  AST_QUAL_DISABLE: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (|hit_vec) |=> (st.disabled & $past(hit_vec)) == $past(hit_vec))
    else $error("string not disabled after qualification");
  AST_RESTART: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (!st.dim_q) |=> st.qual == '0)
    else $error("qualification counter not restarted");
  // No string is newly disabled out of a dimming-low cycle
  AST_DIM_LOW_IDLE: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (!st.dim_q) |=> (st.disabled & ~$past(st.disabled)) == ALL_OFF)
    else $error("action while dimming low");
  AST_DISABLED_SINK_OFF: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (|st.disabled) |-> (st.sink & st.disabled) == ALL_OFF)
    else $error("disabled string still sinking");
  AST_ISOLATE_NO_LATCH: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (!i_latch_all_mode) |-> !st.latched)
    else $error("isolation option latched off");
  AST_EXT_LOW_LATCH_ALL: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (i_latch_all_mode && ext_low) |=> !st.boost && st.sink == ALL_OFF
      && o_disconnect_on == !st.latched)
    else $error("external low did not shut down");
  AST_EXT_LOW_ISOLATE: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (!i_latch_all_mode && !st.latched) |=> st.boost == $past(st.en_q))
    else $error("external low affected isolation option");
  AST_LATCH_HOLD: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (st.latched && st.clr_cnt != CLR_W'(LATCH_CLEAR_CYCLES)) |=> st.latched)
    else $error("latched fault cleared early");
  AST_LATCH_CLEAR: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (st.latched && st.clr_cnt == CLR_W'(LATCH_CLEAR_CYCLES)
      && !(|st.qual)) |=> !st.latched)
    else $error("latched fault not cleared");
  AST_LATCH_ALL_OFF: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (i_latch_all_mode && st.latched) |-> st.sink == ALL_OFF && !st.boost
      && !o_alarm_oe_n)
    else $error("latched device still driving");
  AST_ALARM_HELD: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (|st.faulted) |-> !o_alarm_oe_n)
    else $error("alarm released while string faulted");
  AST_RESUME: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    (!ext_low && !st.latched && st.en_q && $stable(st.en_q))
      |=> st.boost || $past(next_st.latched))
    else $error("no resume after external low removed");
  // Latch clear also drops faults, so exclude that edge
  AST_RELEASE_ONE_EDGE: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    ($fell(|st.faulted) && !$past(st.latched)) |-> $past(dim_rise))
    else $error("alarm released outside dimming edge");
  // Own release must not look like a peer pulling the wire
  AST_RELEASE_MASK: assert property (@(posedge i_sys_clk)
    disable iff (!i_reset_n)
    ($fell(st.alarm_low) && st.en_q) |=> st.boost || st.latched)
    else $error("own alarm release taken as external low");

  COV_SHORT: cover property (@(posedge i_sys_clk) $rose(|st.disabled));
  COV_RELEASE: cover property (@(posedge i_sys_clk) $fell(|st.faulted));
  COV_RETRY: cover property (@(posedge i_sys_clk)
    $fell(|st.disabled) && (|st.faulted));
  COV_EXT_LOW: cover property (@(posedge i_sys_clk)
    i_latch_all_mode && ext_low);
  COV_LATCH_CLR: cover property (@(posedge i_sys_clk) $fell(st.latched));

endmodule // lsf_supervisor

// ---- include/lsf_pkg.sv ----
package lsf_pkg;
  localparam int unsigned NUM_STRINGS     = 4;
  localparam int unsigned CLK_FREQ_MHZ    = 100;
  localparam int unsigned SHORT_QUAL_US   = 2;
  localparam int unsigned SHORT_QUAL_CYC  = SHORT_QUAL_US * CLK_FREQ_MHZ;
  localparam int unsigned LATCH_CLEAR_MS  = 16;
  localparam int unsigned LATCH_CLEAR_CYC = LATCH_CLEAR_MS * 1000
                                            * CLK_FREQ_MHZ;
  localparam int unsigned QUAL_W          = 8;
  localparam int unsigned CLR_W           = 21;
  localparam int unsigned PASS_W          = 2;
  localparam logic [PASS_W-1:0] CLEAN_PASSES_TO_RELEASE = 2'h2;
  localparam logic [NUM_STRINGS-1:0] ALL_OFF = 4'h0;
  localparam logic [NUM_STRINGS-1:0] ALL_ON  = 4'hF;
  localparam logic [2:0] RELEASE_MASK_CYC = 3'h6;
endpackage : lsf_pkg

// ---- dv/lsf_alarm_peer.sv ----
`timescale 1ns/1ps
// Peer on the shared open-drain alarm wire, pulled up, prompt or slow
module lsf_alarm_peer #(
  parameter int unsigned DELAY = 0
) (
  input  wire logic i_sys_clk,
  input  wire logic i_alarm_oe_n,
  input  wire logic i_pull_req,
  output logic      o_wire
);
  localparam int unsigned TAP = (DELAY == 0) ? 0 : DELAY - 1;
  logic [7:0] pipe = 8'h00;
  logic       pull;
  // Delay line for a slow peer
  always_ff @(posedge i_sys_clk) pipe <= {pipe[6:0], i_pull_req};
  // Wire is low whenever either party pulls, else pull-up level
  assign pull   = (DELAY == 0) ? i_pull_req : pipe[TAP];
  assign o_wire = ~(~i_alarm_oe_n | pull);
endmodule // lsf_alarm_peer

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import lsf_pkg::*;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   mode = 1'b0;
  logic                   en = 1'b0;
  logic                   dim = 1'b0;
  logic                   pull = 1'b0;
  logic [NUM_STRINGS-1:0] above = ALL_OFF;
  logic [NUM_STRINGS-1:0] reg_ok = ALL_OFF;
  logic [NUM_STRINGS-1:0] sinks;
  logic                   wire_lvl, a_out, oe_n, boost, disc, flag;
  int                     fails = 0;
  int                     samples_checked = 0;
  int                     s;
  // Free-running system clock
  always #5 clk = ~clk;
  lsf_supervisor #(.LATCH_CLEAR_CYCLES(50)) dut_u (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_latch_all_mode(mode),
    .i_enable(en), .i_dimming(dim), .i_alarm_in(wire_lvl),
    .i_above_short_threshold(above), .i_at_regulation(reg_ok),
    .i_string_used(ALL_ON), .o_alarm_out(a_out), .o_alarm_oe_n(oe_n),
    .o_boost_enable(boost), .o_disconnect_on(disc),
    .o_sink_enable(sinks), .o_fault_flag(flag));
  lsf_alarm_peer #(.DELAY(2)) peer_u (
    .i_sys_clk(clk), .i_alarm_oe_n(oe_n), .i_pull_req(pull),
    .o_wire(wire_lvl));
  // Expected output word {boost, disconnect, flag, oe_n, sinks}
  function automatic logic [7:0] mk(logic b, logic d, logic f, logic o,
                                    logic [NUM_STRINGS-1:0] sk);
    return {b, d, f, o, sk};
  endfunction
  // Compare the live outputs with the model word
  task automatic chk(input logic [7:0] exp);
    samples_checked++;
    if ({boost, disc, flag, oe_n, sinks} !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time,
               {boost, disc, flag, oe_n, sinks}, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Reset with the option strap, then enable with all strings regulating
  task automatic do_reset(input logic m);
    rst_n = 1'b0; mode = m; en = 1'b0; dim = 1'b0; pull = 1'b0;
    above = ALL_OFF; reg_ok = ALL_ON;
    cyc(20);
    chk(mk(1'b0, 1'b1, 1'b0, 1'b1, ALL_OFF));
    rst_n = 1'b1;
    cyc(2);
    en = 1'b1;
  endtask
  // One dimming low gap followed by a rise
  task automatic pulse(input int low);
    dim = 1'b0;
    cyc(low);
    dim = 1'b1;
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Main sequence: string-isolation option, then latch-all option
  initial begin
    void'($urandom(12));
    s = $urandom % NUM_STRINGS;
    do_reset(1'b0);
    dim = 1'b1; cyc(20);
    pull = 1'b1; cyc(12);
    chk(mk(1'b1, 1'b1, 1'b0, 1'b1, ALL_ON));
    pull = 1'b0; dim = 1'b0; above[s] = 1'b1; reg_ok[s] = 1'b0; cyc(250);
    chk(mk(1'b1, 1'b1, 1'b0, 1'b1, ALL_ON));
    dim = 1'b1; cyc(150);
    above[s] = 1'b0; cyc(3); above[s] = 1'b1; cyc(147);
    chk(mk(1'b1, 1'b1, 1'b0, 1'b1, ALL_ON));
    cyc(80);
    chk(mk(1'b1, 1'b1, 1'b1, 1'b0, ALL_ON & ~(4'h1 << s)));
    $display("test isolation qualify done");
    pulse(20); cyc(10);
    chk(mk(1'b1, 1'b1, 1'b1, 1'b0, ALL_ON));
    cyc(220);
    chk(mk(1'b1, 1'b1, 1'b1, 1'b0, ALL_ON & ~(4'h1 << s)));
    above[s] = 1'b0; reg_ok[s] = 1'b1; pulse(20); cyc(230);
    chk(mk(1'b1, 1'b1, 1'b1, 1'b0, ALL_ON));
    pulse(20); cyc(10);
    chk(mk(1'b1, 1'b1, 1'b0, 1'b1, ALL_ON));
    $display("test isolation retry done");
    do_reset(1'b1);
    dim = 1'b1; cyc(20);
    pull = 1'b1; cyc(12);
    chk(mk(1'b0, 1'b1, 1'b0, 1'b1, ALL_OFF));
    pull = 1'b0; cyc(12);
    chk(mk(1'b1, 1'b1, 1'b0, 1'b1, ALL_ON));
    above[s] = 1'b1; reg_ok[s] = 1'b0; cyc(220);
    chk(mk(1'b0, 1'b0, 1'b1, 1'b0, ALL_OFF));
    above[s] = 1'b0; reg_ok[s] = 1'b1; pull = 1'b1; cyc(10); pull = 1'b0;
    pulse(20); cyc(20); pulse(20); cyc(20);
    chk(mk(1'b0, 1'b0, 1'b1, 1'b0, ALL_OFF));
    en = 1'b0; cyc(30);
    chk(mk(1'b0, 1'b0, 1'b1, 1'b0, ALL_OFF));
    cyc(40); en = 1'b1; cyc(12);
    chk(mk(1'b1, 1'b1, 1'b0, 1'b1, ALL_ON));
    $display("test latch-all done");
    results;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results;
  end
endmodule // tb_top
